// File: bench/apsp_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// controller: one reset pulse, only after flag has been low for a while
module apsp_ctrl_model #(
  parameter int RESET_GAP = 16
) (
  input wire logic clk_in, // clock
  input wire logic flag_n_in, // shutdown flag
  input wire logic clear_req_in, // ask for a reset pulse
  input wire logic pair_sel_in, // 0 pair one, 1 pair two
  output logic reset_one_n_out, // pair one reset
  output logic reset_two_n_out // pair two reset
);
  int low_reg = 0;
  int pulse_reg = 0;
  // pwm and bootstrap sense are stood in for by bench levels
  always_ff @(posedge clk_in) begin
    low_reg <= flag_n_in ? 0 : (low_reg < RESET_GAP ? low_reg + 1 : low_reg);
    if (clear_req_in && low_reg == RESET_GAP && pulse_reg == 0) begin
      pulse_reg <= 3;
    end else if (pulse_reg != 0) begin
      pulse_reg <= pulse_reg - 1;
    end
  end
  assign reset_one_n_out = !(pulse_reg != 0 && !pair_sel_in);
  assign reset_two_n_out = !(pulse_reg != 0 && pair_sel_in);
endmodule : apsp_ctrl_model
`default_nettype wire

// File: bench/apsp_protect_test.sv
`timescale 1ns/1ps
`default_nettype none
module apsp_protect_test;
  import apsp_pkg::*;
  localparam int OL = 8;
  localparam int CK = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  apsp_cfg_t cfg = APSP_CFG_BTL;
  apsp_fault_t flt = '0;
  logic otp = 1'b0, uv = 1'b0, sg = 1'b0, sr = 1'b0, ss = 1'b0, clr = 1'b0, sel = 1'b0;
  logic r1_n, r2_n, flag_n, busy, ot_err;
  logic [3:0] hb, cl, rc;
  logic [1:0] ovl;
  int err_total = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  apsp_ctrl_model ctl (.clk_in(clk), .flag_n_in(flag_n), .clear_req_in(clr), .pair_sel_in(sel),
    .reset_one_n_out(r1_n), .reset_two_n_out(r2_n));
  apsp_protect #(.OVERLOAD_CNT(OL), .CHECK_CNT(CK)) dut (.mclk_in(clk), .reset_in(rst), .cfg_in(cfg),
    .fault_in(flt), .overtemp_in(otp), .supply_undervoltage_in(uv), .short_gnd_in(sg), .short_rail_in(sr),
    .soft_start_in(ss), .reset_pair_one_n_in(r1_n), .reset_pair_two_n_in(r2_n), .hb_enable_out(hb),
    .current_limit_out(cl), .recharge_out(rc), .overload_protect_out(ovl), .overtemp_error_out(ot_err),
    .check_busy_out(busy), .fault_shutdown_flag_n_out(flag_n));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic wait_run();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) cyc(1);
    if (busy !== 1'b0) begin
      err_total++;
      report_and_stop();
    end
  endtask : wait_run
  task automatic clear_pulse(input logic s);
    sel = s;
    clr = 1'b1;
    for (int i = 0; i < 80 && (s ? r2_n : r1_n) !== 1'b0; i++) cyc(1);
    if ((s ? r2_n : r1_n) !== 1'b0) begin
      err_total++;
      report_and_stop();
    end
    clr = 1'b0;
    cyc(1);
    chk({3'h0, flag_n}, 4'h1);
    cyc(5);
  endtask : clear_pulse
  task automatic t_check();
    for (int k = 0; k < 3; k++) begin
      sg = (k == 1);
      sr = (k == 2);
      rst = 1'b1;
      cyc(6);
      rst = 1'b0;
      cyc(2);
      chk({3'h0, flag_n}, 4'h0);
      cyc(2 * CK + 6);
      if (k > 0) chk({3'h0, busy}, 4'h1);
      if (k > 0) chk(hb, NO_BITS);
      sg = 1'b0;
      sr = 1'b0;
      wait_run();
      cyc(2);
      chk(hb, ALL_BITS);
      chk({3'h0, flag_n}, 4'h1);
    end
    sg = 1'b1;
    cyc(4);
    chk(hb, ALL_BITS);
    sg = 1'b0;
    $display("t_check done");
  endtask : t_check
  task automatic t_group();
    logic [3:0] e;
    for (int c = 0; c < 3; c++) begin
      for (int b = 0; b < 4; b++) begin
        cfg = apsp_cfg_t'(c[1:0]);
        e = (c == 0) ? (b < 2 ? PAIR_TWO_BITS : PAIR_ONE_BITS) : (c == 1) ? NO_BITS : ~(4'h1 << b);
        cyc(2);
        flt.other_fault = 4'h1 << b;
        cyc(2);
        chk(hb, e);
        chk({3'h0, flag_n}, 4'h0);
        flt = '0;
        cyc(2);
        chk(hb, ALL_BITS);
      end
    end
    cfg = APSP_CFG_BTL;
    $display("t_group done");
  endtask : t_group
  task automatic t_misc();
    flt.bootstrap_undervoltage = 4'h4;
    cyc(2);
    chk(hb, 4'hB);
    chk(rc, 4'h4);
    flt = '0;
    uv = 1'b1;
    cyc(2);
    chk(hb, NO_BITS);
    uv = 1'b0;
    cyc(2);
    chk(hb, ALL_BITS);
    ss = 1'b1;
    cyc(2);
    chk(hb, NO_BITS);
    cyc(4 * SOFT_STEP_CYCLES + 4);
    chk(hb, ALL_BITS);
    ss = 1'b0;
    $display("t_misc done");
  endtask : t_misc
  task automatic t_overload();
    flt.overcurrent = 4'h1;
    cyc(2);
    chk(cl, 4'h1);
    chk(hb, ALL_BITS);
    cyc(OL + 5);
    chk({2'h0, ovl}, 4'h1);
    chk(hb, PAIR_TWO_BITS);
    flt = '0;
    cyc(4);
    chk({2'h0, ovl}, 4'h1);
    clear_pulse(1'b0);
    chk({2'h0, ovl}, 4'h0);
    chk(hb, ALL_BITS);
    $display("t_overload done");
  endtask : t_overload
  task automatic t_otemp();
    otp = 1'b1;
    cyc(2);
    chk(hb, NO_BITS);
    otp = 1'b0;
    cyc(4);
    chk({3'h0, ot_err}, 4'h1);
    clear_pulse(1'b1);
    chk({3'h0, ot_err}, 4'h0);
    chk(hb, ALL_BITS);
    $display("t_otemp done");
  endtask : t_otemp
  initial begin
    t_check();
    t_group();
    t_misc();
    t_overload();
    t_otemp();
    report_and_stop();
  end
endmodule : apsp_protect_test
`default_nettype wire

// File: core/apsp_pkg.sv
package apsp_pkg;
  localparam int NUM_HB = 4;
  // output configuration
  typedef enum logic [1:0] {
    APSP_CFG_BTL = 2'b00,
    APSP_CFG_PBTL = 2'b01,
    APSP_CFG_SE = 2'b10
  } apsp_cfg_t;
  // startup short check states
  typedef enum logic [2:0] {
    APSP_ST_POWERUP = 3'b000,
    APSP_ST_GND_CHECK = 3'b001,
    APSP_ST_RAIL_CHECK = 3'b010,
    APSP_ST_SHORT_HOLD = 3'b011,
    APSP_ST_RUN = 3'b100
  } apsp_state_t;
  // per half-bridge fault inputs
  typedef struct packed {
    logic [3:0] bootstrap_undervoltage;
    logic [3:0] overcurrent;
    logic [3:0] other_fault;
  } apsp_fault_t;
  localparam int CLK_MHZ = 250;
  localparam int PAIR_ONE_MASK_IDX = 0;
  localparam logic [3:0] PAIR_ONE_BITS = 4'h3;
  localparam logic [3:0] PAIR_TWO_BITS = 4'hC;
  localparam logic [3:0] ALL_BITS = 4'hF;
  localparam logic [3:0] NO_BITS = 4'h0;
  localparam int OVERLOAD_TIME_US = 10;
  localparam int OVERLOAD_CYCLES = OVERLOAD_TIME_US * CLK_MHZ;
  localparam int RECHARGE_TIME_NS = 100;
  localparam int RECHARGE_CYCLES = (RECHARGE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CHECK_TIME_US = 20;
  localparam int CHECK_CYCLES = CHECK_TIME_US * CLK_MHZ;
  localparam int SOFT_STEP_CYCLES = 64;
endpackage : apsp_pkg

// File: core/apsp_protect.sv
`timescale 1ns/1ps
`default_nettype none
module apsp_protect
  import apsp_pkg::*;
#(
  parameter int OVERLOAD_CNT = OVERLOAD_CYCLES,
  parameter int CHECK_CNT = CHECK_CYCLES
) (
  input wire logic mclk_in, // 250 MHz clock
  input wire logic reset_in, // sync reset, high
  input wire apsp_cfg_t cfg_in, // output configuration
  input wire apsp_fault_t fault_in, // per half-bridge faults
  input wire logic overtemp_in, // overtemperature error level
  input wire logic supply_undervoltage_in, // supply undervoltage
  input wire logic short_gnd_in, // any output shorted to ground
  input wire logic short_rail_in, // any output shorted to rail
  input wire logic soft_start_in, // soft-start pulse series active
  input wire logic reset_pair_one_n_in, // pair A/B reset, low
  input wire logic reset_pair_two_n_in, // pair C/D reset, low
  output logic [3:0] hb_enable_out, // half-bridge drive enable
  output logic [3:0] current_limit_out, // current limit active
  output logic [3:0] recharge_out, // bootstrap recharge request
  output logic [1:0] overload_protect_out, // latched overload per pair
  output logic overtemp_error_out, // latched overtemp error
  output logic check_busy_out, // short check running
  output logic fault_shutdown_flag_n_out // shutdown flag, low
);
  // ******************************
  // startup short check
  // ******************************
  apsp_state_t state_reg, state_next;
  logic [$clog2(CHECK_CNT+1)-1:0] chk_cnt_reg;
  wire chk_done = (chk_cnt_reg == ($bits(chk_cnt_reg))'(CHECK_CNT - 1));
  wire se_mode = (cfg_in == APSP_CFG_SE);
  wire running = (state_reg == APSP_ST_RUN);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      APSP_ST_POWERUP: state_next = se_mode ? APSP_ST_RUN : APSP_ST_GND_CHECK;
      APSP_ST_GND_CHECK: if (short_gnd_in) state_next = APSP_ST_SHORT_HOLD;
        else if (chk_done) state_next = APSP_ST_RAIL_CHECK;
      APSP_ST_RAIL_CHECK: if (short_rail_in) state_next = APSP_ST_SHORT_HOLD;
        else if (chk_done) state_next = APSP_ST_RUN;
      APSP_ST_SHORT_HOLD: if (!short_gnd_in && !short_rail_in) state_next = APSP_ST_GND_CHECK;
      APSP_ST_RUN: state_next = APSP_ST_RUN;
      default: state_next = APSP_ST_POWERUP;
    endcase
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= APSP_ST_POWERUP;
      chk_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      chk_cnt_reg <= (state_next != state_reg || chk_done) ? '0 : chk_cnt_reg + 1'b1;
    end
  end
  // ******************************
  // reset pins, ignored during check
  // ******************************
  logic [1:0] rst_n_reg;
  wire [1:0] rst_n_now = {reset_pair_two_n_in, reset_pair_one_n_in};
  wire [1:0] rst_rise = running ? (rst_n_now & ~rst_n_reg) : 2'b00;
  wire any_rst_low = running && (rst_n_now != 2'b11);
  wire [3:0] rst_hiz = running ? {{2{~rst_n_now[1]}}, {2{~rst_n_now[0]}}} : NO_BITS;
  always_ff @(posedge mclk_in) begin
    if (reset_in) rst_n_reg <= '1; // idle high, no false edge after reset
    else rst_n_reg <= rst_n_now;
  end
  // ******************************
  // overcurrent: limit, then latch per pair
  // ******************************
  logic [1:0] ol_reg;
  logic ot_err_reg;
  logic [$clog2(OVERLOAD_CNT+1)-1:0] ovc_cnt_reg [2];
  wire [1:0] pair_ovc = {|fault_in.overcurrent[3:2], |fault_in.overcurrent[1:0]};
  wire [1:0] ol_trip;
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pair
      assign ol_trip[gp] = pair_ovc[gp] && (ovc_cnt_reg[gp] == ($bits(ovc_cnt_reg[gp]))'(OVERLOAD_CNT - 1));
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          ovc_cnt_reg[gp] <= '0;
          ol_reg[gp] <= 1'b0;
        end else begin
          ovc_cnt_reg[gp] <= (pair_ovc[gp] && !ol_trip[gp]) ? ovc_cnt_reg[gp] + 1'b1 : '0;
          if (ol_trip[gp]) ol_reg[gp] <= 1'b1;
          else if (|rst_rise) ol_reg[gp] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge mclk_in) begin
    if (reset_in) ot_err_reg <= 1'b0;
    else if (overtemp_in) ot_err_reg <= 1'b1;
    else if (any_rst_low) ot_err_reg <= 1'b0;
  end
  // ******************************
  // shutdown grouping
  // ******************************
  wire [3:0] local_err = fault_in.other_fault;
  wire [3:0] grp_btl = {{2{|local_err[3:2]}}, {2{|local_err[1:0]}}};
  wire [3:0] grp_err = (cfg_in == APSP_CFG_PBTL) ? {4{|local_err}} : (se_mode ? local_err : grp_btl);
  wire [3:0] ol_off = {{2{ol_reg[1]}}, {2{ol_reg[0]}}};
  wire global_off = ot_err_reg || supply_undervoltage_in || !running;
  wire [3:0] fault_off = grp_err | ol_off | fault_in.bootstrap_undervoltage | (global_off ? ALL_BITS : NO_BITS);
  wire [3:0] hb_off = fault_off | rst_hiz;
  // ******************************
  // soft start ramp
  // ******************************
  logic [5:0] soft_cnt_reg;
  logic [3:0] soft_mask_reg;
  logic soft_seen_reg;
  // ramp starts once per pulse series, never again while it lasts
  always_ff @(posedge mclk_in) begin
    if (reset_in || !soft_start_in) begin
      soft_cnt_reg <= '0;
      soft_mask_reg <= ALL_BITS;
      soft_seen_reg <= 1'b0;
    end else begin
      soft_cnt_reg <= soft_cnt_reg + 1'b1;
      soft_seen_reg <= 1'b1;
      if (!soft_seen_reg) soft_mask_reg <= NO_BITS;
      else if (soft_cnt_reg == 6'(SOFT_STEP_CYCLES - 1)) soft_mask_reg <= {soft_mask_reg[2:0], 1'b1};
    end
  end
  // ******************************
  // outputs
  // ******************************
  wire flag_n_next = any_rst_low ? 1'b1 : !(|fault_off);
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hb_enable_out <= NO_BITS;
      current_limit_out <= NO_BITS;
      recharge_out <= NO_BITS;
      overload_protect_out <= 2'b00;
      overtemp_error_out <= 1'b0;
      check_busy_out <= 1'b0;
      fault_shutdown_flag_n_out <= 1'b0;
    end else begin
      hb_enable_out <= ~hb_off & soft_mask_reg;
      current_limit_out <= fault_in.overcurrent & ~ol_off;
      recharge_out <= fault_in.bootstrap_undervoltage;
      overload_protect_out <= ol_reg;
      overtemp_error_out <= ot_err_reg;
      check_busy_out <= !running;
      fault_shutdown_flag_n_out <= flag_n_next;
    end
  end
  // ******************************
  // assertions
  // ******************************
  bst_local_off_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    fault_in.bootstrap_undervoltage[0] |=> !hb_enable_out[0])
    else $error("bootstrap fault did not stop half-bridge");
  fault_flag_low_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (|fault_in.other_fault && !any_rst_low) |=> !fault_shutdown_flag_n_out)
    else $error("fault did not drop flag");
  reset_flag_high_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    any_rst_low |=> fault_shutdown_flag_n_out)
    else $error("reset low did not force flag high");
  check_flag_low_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !running |=> !fault_shutdown_flag_n_out)
    else $error("flag high during short check");
  overload_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (ol_reg[0] && !(|rst_rise)) |=> ol_reg[0])
    else $error("overload latch dropped without reset");
  pair_isolated_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (ol_reg == 2'b01 && !global_off && local_err == NO_BITS && !(|rst_hiz)
     && fault_in.bootstrap_undervoltage == NO_BITS && soft_mask_reg == ALL_BITS)
    |=> hb_enable_out == PAIR_TWO_BITS)
    else $error("overload on pair one affected pair two");
  pbtl_all_off_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (cfg_in == APSP_CFG_PBTL && local_err[0]) |=> hb_enable_out == NO_BITS)
    else $error("parallel mode fault did not stop all");
  overtemp_latch_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (ot_err_reg && !any_rst_low) |=> ot_err_reg)
    else $error("overtemp latch lost");
  overload_clear_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (|rst_rise && ol_trip == 2'b00) |=> ol_reg == 2'b00)
    else $error("reset edge did not clear overload");
  current_limit_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (fault_in.overcurrent[0] && !ol_reg[0]) |=> current_limit_out[0])
    else $error("overcurrent not limited");
  short_hold_off_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (state_reg == APSP_ST_SHORT_HOLD) |=> hb_enable_out == NO_BITS)
    else $error("half-bridge on while short held");
  gnd_before_rail_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (state_reg == APSP_ST_RAIL_CHECK)
    |-> ($past(state_reg) == APSP_ST_GND_CHECK || $past(state_reg) == APSP_ST_RAIL_CHECK))
    else $error("rail step not after ground step");
  run_not_busy_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    running |=> !check_busy_out)
    else $error("short check active after startup");
  soft_ramp_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(soft_start_in) |=> soft_mask_reg == NO_BITS)
    else $error("soft start did not begin from all off");
  overtemp_flag_low_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (ot_err_reg && !any_rst_low) |=> !fault_shutdown_flag_n_out)
    else $error("flag high while overtemp latched");
  recharge_track_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    (fault_in.bootstrap_undervoltage != NO_BITS) |=> recharge_out == $past(fault_in.bootstrap_undervoltage))
    else $error("recharge request does not follow bootstrap fault");
endmodule : apsp_protect
`default_nettype wire
